// [adcseq_defs.svh]
// constants for the converter state sequencer: offsets, fields, resets, timing
`ifndef ADCSEQ_DEFS_SVH
`define ADCSEQ_DEFS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define ADCSEQ_OFS_CONTROL     5'h00
`define ADCSEQ_OFS_STATUS      5'h04
`define ADCSEQ_OFS_RESULT      5'h08
`define ADCSEQ_OFS_COEF_OFFSET 5'h0c
`define ADCSEQ_OFS_COEF_GAIN   5'h10

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define ADCSEQ_CTRL_SLEEP_BIT  0
`define ADCSEQ_STAT_STATE_LSB  0
`define ADCSEQ_STAT_STATE_MSB  5
`define ADCSEQ_STAT_PCAL_BIT   8
`define ADCSEQ_STAT_PCONV_BIT  9
`define ADCSEQ_STAT_CHAN_LSB   12
`define ADCSEQ_STAT_CHAN_MSB   13
`define ADCSEQ_STAT_READY_BIT  16
`define ADCSEQ_STAT_CALOK_BIT  17
`define ADCSEQ_CTRL_RESET      1'b0

// ----------------------------------------------------------------------------
// timing, in master clock cycles unless marked
// ----------------------------------------------------------------------------
`define ADCSEQ_CLOCK_KHZ       125000
`define ADCSEQ_POR_DELAY_MS    10
`define ADCSEQ_POR_CYCLES      (`ADCSEQ_POR_DELAY_MS * `ADCSEQ_CLOCK_KHZ)
`define ADCSEQ_WAKE_CYCLES     1800
`define ADCSEQ_CAL_CYCLES      3246
`define ADCSEQ_SAMPLE_REQUEST_CYCLES     1622
`define ADCSEQ_FIRST_CYCLES    1624

`endif

// [adcseq_pkg.sv]
// types for the converter state sequencer
package adcseq_pkg;

  // --------------------------------------------------------------------------
  // sequencer states, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [5:0] {
    ADCSEQ_POR     = 6'h01,
    ADCSEQ_WAKE    = 6'h02,
    ADCSEQ_STANDBY = 6'h04,
    ADCSEQ_CAL     = 6'h08,
    ADCSEQ_SAMPLE_REQUEST    = 6'h10,
    ADCSEQ_SLEEP   = 6'h20
  } adcseq_state_t;

  // --------------------------------------------------------------------------
  // pin group as sampled, two stages
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       trim;
    logic       sample;
    logic [1:0] chan;
    logic       polarity;
  } adcseq_pins_t;

endpackage

// [adcseq_top.sv]
// converter state sequencer with avalon-mm register slave
//
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "adcseq_defs.svh"

// Summary of operation
// - states are start-up, calibration, conversion and sleep; standby is idle.
// - after power-on, hold logic in reset about ten milliseconds.
// - then count 1800 master clocks of wake-up before acting.
// - commands seen during wake-up are remembered, run after wake-up ends.
// - with no command pending at wake-up end, go to standby.
// - calibration does offset step first, then gain step.
// - trim-request and sample-request both high enters calibration.
// - pin levels at power-on and sleep exit count as commands.
// - each rising sample-request latches both channel-select inputs.
// - calibration command in standby starts calibration at once.
// - calibration lasts 3246 master clocks.
// - finished calibration stores offset and gain coefficients on chip.
// - at calibration end, sample-request high converts, low goes standby.
// - sample-request re-rising with trim-request high restarts calibration.
// - sample-request re-rising with trim-request low during calibration is ignored.
// - channel and polarity inputs do not affect calibration.
// - trim pulse with sample held high gives ready strobe after conversion.
// - conversion start latches channel; output updates at filter completion.
// - continuous conversions on held sample-request take 1622 clocks each.
// - conversion from standby takes 1624 clocks before ready falls.
module adcseq_top
  import adcseq_pkg::*;
#(
  parameter int DATA_W     = 20,
  parameter int POR_CYCLES = `ADCSEQ_POR_CYCLES
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              trim_request,
  input  wire logic              sample_request,
  input  wire logic              channel_sel_lo,
  input  wire logic              channel_sel_hi,
  input  wire logic              polarity_select,
  input  wire logic [DATA_W-1:0] filter_result,
  input  wire logic [DATA_W-1:0] offset_measure,
  input  wire logic [DATA_W-1:0] gain_measure,
  output logic                   result_ready_n,
  output logic [DATA_W-1:0]      result_data,
  output logic [1:0]             active_channel,
  output logic                   calibrating,
  input  wire logic [4:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest
);

  // --------------------------------------------------------------------------
  // sizes and checks
  // --------------------------------------------------------------------------
  localparam int CNT_W = 22;
  localparam logic [CNT_W-1:0] POR_LAST   = CNT_W'(POR_CYCLES - 1);
  localparam logic [CNT_W-1:0] WAKE_LAST  = CNT_W'(`ADCSEQ_WAKE_CYCLES - 1);
  localparam logic [CNT_W-1:0] CAL_LAST   = CNT_W'(`ADCSEQ_CAL_CYCLES - 1);
  localparam logic [CNT_W-1:0] CAL_HALF   = CNT_W'(`ADCSEQ_CAL_CYCLES / 2);
  localparam logic [CNT_W-1:0] SAMPLE_REQUEST_LAST  = CNT_W'(`ADCSEQ_SAMPLE_REQUEST_CYCLES - 1);
  localparam logic [CNT_W-1:0] FIRST_LAST = CNT_W'(`ADCSEQ_FIRST_CYCLES - 1);
  localparam logic [DATA_W-1:0] BIPOLAR_OFS = {1'b1, {(DATA_W-1){1'b0}}};

  if (POR_CYCLES < 1 || POR_CYCLES >= (1 << CNT_W)) begin : g_por_chk
    $error("POR_CYCLES out of counter range");
  end
  if (DATA_W < 2 || DATA_W > 32) begin : g_width_chk
    $error("DATA_W must lie between 2 and 32");
  end

  // --------------------------------------------------------------------------
  // whole state of the block
  // --------------------------------------------------------------------------
  typedef struct packed {
    adcseq_pins_t      sync1;
    adcseq_pins_t      sync2;
    logic              sample_prev;
    adcseq_state_t     state;
    logic [CNT_W-1:0]  cnt;
    logic              first_sample_request;
    logic              pend_cal;
    logic              pend_sample_request;
    logic [1:0]        chan_latch;
    logic [1:0]        chan_active;
    logic              ready_n;
    logic [DATA_W-1:0] result;
    logic [DATA_W-1:0] coef_offset;
    logic [DATA_W-1:0] coef_gain;
    logic              cal_valid;
    logic              sleep_cmd;
    logic              waitreq;
    logic [31:0]       rdata;
  } adcseq_regs_t;

  adcseq_regs_t r;
  adcseq_regs_t next_r;

  logic         sample_rise;
  logic         cal_cmd;
  logic         bus_req;
  logic         bus_hit;
  logic [31:0]  status_word;

  // --------------------------------------------------------------------------
  // derived terms
  // --------------------------------------------------------------------------
  // only the second sync stage feeds any logic
  assign sample_rise = r.sync2.sample & ~r.sample_prev;
  assign cal_cmd     = r.sync2.trim & r.sync2.sample;
  assign bus_req     = avs_read | avs_write;
  assign bus_hit     = bus_req & r.waitreq;

  always_comb begin
    status_word = 32'h0;
    status_word[`ADCSEQ_STAT_STATE_MSB:`ADCSEQ_STAT_STATE_LSB] = r.state;
    status_word[`ADCSEQ_STAT_PCAL_BIT]  = r.pend_cal;
    status_word[`ADCSEQ_STAT_PCONV_BIT] = r.pend_sample_request;
    status_word[`ADCSEQ_STAT_CHAN_MSB:`ADCSEQ_STAT_CHAN_LSB] = r.chan_active;
    status_word[`ADCSEQ_STAT_READY_BIT] = ~r.ready_n;
    status_word[`ADCSEQ_STAT_CALOK_BIT] = r.cal_valid;
  end

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.sync1 = '{trim: trim_request, sample: sample_request,
                     chan: {channel_sel_hi, channel_sel_lo}, polarity: polarity_select};
    next_r.sync2 = r.sync1;
    next_r.sample_prev = r.sync2.sample;

    // channel latch follows every rising edge; calibration reads it only at its end, to pick the channel of the next conversion
    if (sample_rise) begin
      next_r.chan_latch = r.sync2.chan;
    end

    case (r.state)
      ADCSEQ_POR: begin
        // logic held idle for the power-on delay
        if (r.cnt == POR_LAST) begin
          next_r.state = ADCSEQ_WAKE;
          next_r.cnt   = '0;
        end else begin
          next_r.cnt = r.cnt + CNT_W'(1);
        end
      end

      ADCSEQ_WAKE: begin
        // commands are caught here but act only when the count runs out
        if (cal_cmd) begin
          next_r.pend_cal = 1'b1;
        end
        if (sample_rise || r.sync2.sample) begin
          next_r.pend_sample_request = 1'b1;
        end
        if (r.cnt == WAKE_LAST) begin
          next_r.cnt       = '0;
          next_r.pend_cal  = 1'b0;
          next_r.pend_sample_request = 1'b0;
          if (r.pend_cal || cal_cmd) begin
            next_r.state = ADCSEQ_CAL;
          end else if (r.pend_sample_request || r.sync2.sample) begin
            next_r.state       = ADCSEQ_SAMPLE_REQUEST;
            next_r.first_sample_request  = 1'b1;
            next_r.chan_active = sample_rise ? r.sync2.chan : r.chan_latch;
            next_r.ready_n     = 1'b1;
          end else begin
            next_r.state = ADCSEQ_STANDBY;
          end
        end else begin
          next_r.cnt = r.cnt + CNT_W'(1);
        end
      end

      ADCSEQ_STANDBY: begin
        next_r.cnt = '0;
        if (cal_cmd) begin
          next_r.state = ADCSEQ_CAL;
        end else if (sample_rise) begin
          next_r.state       = ADCSEQ_SAMPLE_REQUEST;
          next_r.first_sample_request  = 1'b1;
          next_r.chan_active = r.sync2.chan;
          next_r.ready_n     = 1'b1;
        end else if (r.sleep_cmd) begin
          next_r.state = ADCSEQ_SLEEP;
        end
      end

      ADCSEQ_CAL: begin
        // trim level is not looked at again except on a fresh sample edge
        if (sample_rise && r.sync2.trim) begin
          next_r.cnt = '0;
        end else if (r.cnt == CAL_LAST) begin
          next_r.cnt       = '0;
          next_r.coef_gain = gain_measure;
          next_r.cal_valid = 1'b1;
          if (r.sync2.sample) begin
            next_r.state       = ADCSEQ_SAMPLE_REQUEST;
            next_r.first_sample_request  = 1'b1;
            next_r.chan_active = r.chan_latch;
            next_r.ready_n     = 1'b1;
          end else begin
            next_r.state = ADCSEQ_STANDBY;
          end
        end else begin
          // a lone sample edge with trim low falls through here unused
          next_r.cnt = r.cnt + CNT_W'(1);
          if (r.cnt == CAL_HALF) begin
            next_r.coef_offset = offset_measure;
          end
        end
      end

      ADCSEQ_SAMPLE_REQUEST: begin
        if (cal_cmd) begin
          // both requests high outranks the running conversion
          next_r.state   = ADCSEQ_CAL;
          next_r.cnt     = '0;
          next_r.ready_n = 1'b1;
        end else if (sample_rise) begin
          // new command cuts the running conversion short
          next_r.cnt         = '0;
          next_r.first_sample_request  = 1'b1;
          next_r.chan_active = r.sync2.chan;
          next_r.ready_n     = 1'b1;
        end else if ((r.first_sample_request && r.cnt == FIRST_LAST) ||
                     (!r.first_sample_request && r.cnt == SAMPLE_REQUEST_LAST)) begin
          next_r.cnt     = '0;
          next_r.result  = r.sync2.polarity ? filter_result + BIPOLAR_OFS
                                            : filter_result;
          next_r.ready_n = 1'b0;
          next_r.first_sample_request = 1'b0;
          if (!r.sync2.sample) begin
            next_r.state = ADCSEQ_STANDBY;
          end
        end else begin
          next_r.cnt = r.cnt + CNT_W'(1);
          // strobe returns high once the next conversion is under way
          if (r.cnt == CNT_W'(0) && !r.ready_n && !r.first_sample_request) begin
            next_r.ready_n = 1'b1;
          end
        end
      end

      ADCSEQ_SLEEP: begin
        next_r.cnt = '0;
        if (!r.sleep_cmd) begin
          next_r.state     = ADCSEQ_WAKE;
          next_r.pend_cal  = 1'b0;
          next_r.pend_sample_request = 1'b0;
        end
      end

      default: begin
        next_r.state = ADCSEQ_POR;
        next_r.cnt   = '0;
      end
    endcase

    // ------------------------------------------------------------------------
    // avalon slave: one wait cycle, then answer
    // ------------------------------------------------------------------------
    next_r.waitreq = ~bus_hit;
    if (bus_hit && avs_read) begin
      case (avs_address)
        `ADCSEQ_OFS_CONTROL:     next_r.rdata = {31'h0, r.sleep_cmd};
        `ADCSEQ_OFS_STATUS:      next_r.rdata = status_word;
        `ADCSEQ_OFS_RESULT:      next_r.rdata = 32'(r.result);
        `ADCSEQ_OFS_COEF_OFFSET: next_r.rdata = 32'(r.coef_offset);
        `ADCSEQ_OFS_COEF_GAIN:   next_r.rdata = 32'(r.coef_gain);
        default:                 next_r.rdata = 32'h0;
      endcase
    end
    // write lands at the edge where waitrequest is seen low
    if (avs_write && !r.waitreq && avs_address == `ADCSEQ_OFS_CONTROL && avs_byteenable[0]) begin
      next_r.sleep_cmd = avs_writedata[`ADCSEQ_CTRL_SLEEP_BIT];
    end

    // power-on reset is the only reset and restarts from start-up
    if (rst) begin
      next_r             = '0;
      next_r.state       = ADCSEQ_POR;
      next_r.ready_n     = 1'b1;
      next_r.waitreq     = 1'b1;
      next_r.sleep_cmd   = `ADCSEQ_CTRL_RESET;
    end
  end

  // --------------------------------------------------------------------------
  // state register, synchronous reset folded into next_r
  // --------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    r <= next_r;
  end

  // --------------------------------------------------------------------------
  // outputs straight from flops
  // --------------------------------------------------------------------------
  assign result_ready_n  = r.ready_n;
  assign result_data     = r.result;
  assign active_channel  = r.chan_active;
  assign calibrating     = r.state[3];
  assign avs_readdata    = r.rdata;
  assign avs_waitrequest = r.waitreq;

endmodule // adcseq_top

// [adcseq_checker_asserts.sv]
// assertion checker for the converter state sequencer
`timescale 1ns/1ps
module adcseq_checker #(
  parameter int DATA_W     = 20,
  parameter int POR_CYCLES = 20
) (
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              trim_request,
  input wire logic              sample_request,
  input wire logic              channel_sel_lo,
  input wire logic              channel_sel_hi,
  input wire logic              result_ready_n,
  input wire logic [DATA_W-1:0] result_data,
  input wire logic [1:0]        active_channel,
  input wire logic              calibrating
);
  // ----------------------------------------
  // event counters
  // ----------------------------------------
  // up_cnt and the since_ counters saturate, so a stale event never aliases a fresh one; cal_cnt clears outside calibration
  logic [15:0] up_cnt, since_rise, since_fall, since_cal_end, cal_cnt;
  logic [1:0]  chan_l;
  logic        awake;
  assign awake = up_cnt > 16'(POR_CYCLES + 1808);
  always_ff @(posedge clock) begin
    if (rst) begin
      up_cnt        <= 16'h0;
      since_rise    <= 16'hffff;
      since_fall    <= 16'hffff;
      since_cal_end <= 16'hffff;
      cal_cnt       <= 16'h0;
      chan_l        <= {channel_sel_hi, channel_sel_lo};
    end else begin
      up_cnt        <= up_cnt + {15'h0, ~&up_cnt};
      since_rise    <= $rose(sample_request) ? 16'h1 : since_rise + {15'h0, ~&since_rise};
      since_fall    <= $fell(result_ready_n) ? 16'h1 : since_fall + {15'h0, ~&since_fall};
      since_cal_end <= $fell(calibrating) ? 16'h1 : since_cal_end + {15'h0, ~&since_cal_end};
      cal_cnt       <= calibrating ? cal_cnt + 16'h1 : 16'h0;
      chan_l        <= $rose(sample_request) ? {channel_sel_hi, channel_sel_lo} : chan_l;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  cal_length_a: assert property ($fell(calibrating) && since_rise > 16'd3260 |-> cal_cnt == 16'd3246)
    else $error("calibration run length wrong");
  sample_request_start_a: assert property ($fell(result_ready_n) && since_rise < 16'd2000 |-> since_rise inside {[16'd1626:16'd1630]})
    else $error("standby conversion length wrong");
  sample_request_period_a: assert property ($fell(result_ready_n) && since_fall < 16'd1700 |-> since_fall == 16'd1622)
    else $error("continuous conversion period wrong");
  cal_entry_a: assert property ($rose(trim_request) && sample_request && awake && !calibrating |-> ##[2:6] calibrating)
    else $error("calibration not entered");
  cal_to_sample_request_a: assert property ($fell(result_ready_n) && since_cal_end < 16'd1700 |-> since_cal_end inside {[16'd1623:16'd1626]})
    else $error("conversion after calibration mistimed");
  result_hold_a: assert property (!$stable(result_data) |-> $fell(result_ready_n))
    else $error("result changed outside conversion end");
  chan_latch_a: assert property ($fell(result_ready_n) |-> active_channel == chan_l)
    else $error("channel not the latched one");
  trim_drop_a: assert property (calibrating && $fell(trim_request) |-> calibrating[*8])
    else $error("trim drop disturbed calibration");
  sample_request_ignored_a: assert property (calibrating && !trim_request && $rose(sample_request) |=> $stable(calibrating)[*8])
    else $error("sample edge broke calibration");
  cover property ($fell(calibrating) && sample_request);
  cover property ($rose(calibrating) && awake);
  cover property ($fell(result_ready_n) && since_rise < 16'd2000);
endmodule // adcseq_checker

bind adcseq_top adcseq_checker #(.DATA_W(DATA_W), .POR_CYCLES(POR_CYCLES)) i_chk (
  .clock(clock), .rst(rst), .trim_request(trim_request), .sample_request(sample_request),
  .channel_sel_lo(channel_sel_lo), .channel_sel_hi(channel_sel_hi), .result_ready_n(result_ready_n),
  .result_data(result_data), .active_channel(active_channel), .calibrating(calibrating));

// [adcseq_host.sv]
// host model that drives the converter command and channel pins
`timescale 1ns/1ps
module adcseq_host (
  input  wire logic clock,
  output logic      trim_request,
  output logic      sample_request,
  output logic      channel_sel_lo,
  output logic      channel_sel_hi,
  output logic      polarity_select
);
  // ----------------------------------------
  // pin driver
  // ----------------------------------------
  // both requests high from power-on: the first command is a calibration
  initial begin
    trim_request    = 1'b1;
    sample_request  = 1'b1;
    channel_sel_lo  = 1'b0;
    channel_sel_hi  = 1'b0;
    polarity_select = 1'b0;
  end
  // pins move together after an edge; a cal is disturbed only when a test asks
  task automatic set_pins(input logic t, input logic s, input logic [1:0] ch, input logic p);
    @(posedge clock);
    trim_request    <= t;
    sample_request  <= s;
    channel_sel_hi  <= ch[1];
    channel_sel_lo  <= ch[0];
    polarity_select <= p;
  endtask
endmodule // adcseq_host

// [adc_state_sequencer_tb.sv]
// self-checking bench for the converter state sequencer
`timescale 1ns/1ps
module adc_state_sequencer_tb;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        trim_request, sample_request, channel_sel_lo, channel_sel_hi, polarity_select;
  logic [19:0] filter_result = 20'h12345;
  logic [19:0] result_data;
  logic [1:0]  active_channel;
  logic        result_ready_n, calibrating, avs_waitrequest;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          n, a;
  time         t0;

  always #4 clock = ~clock;

  adcseq_top #(.DATA_W(20), .POR_CYCLES(20)) i_dut (
    .clock(clock), .rst(rst), .trim_request(trim_request), .sample_request(sample_request),
    .channel_sel_lo(channel_sel_lo), .channel_sel_hi(channel_sel_hi), .polarity_select(polarity_select),
    .filter_result(filter_result), .offset_measure(20'h00abc), .gain_measure(20'h7f0e1),
    .result_ready_n(result_ready_n), .result_data(result_data), .active_channel(active_channel),
    .calibrating(calibrating), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  adcseq_host i_host (
    .clock(clock), .trim_request(trim_request), .sample_request(sample_request),
    .channel_sel_lo(channel_sel_lo), .channel_sel_hi(channel_sel_hi), .polarity_select(polarity_select));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic timeout(input string what);
    check(what, 32'h1, 32'h0);
    report_and_stop;
  endtask
  // request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [4:0] adr, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clock);
    avs_address   <= adr;
    avs_writedata <= d;
    avs_read      <= ~wr;
    avs_write     <= wr;
    // waitrequest is looked at mid-cycle, where it has settled
    for (i = 0; i < 50; i++) begin
      @(negedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    @(posedge clock);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (i == 50) timeout("bus answer");
  endtask
  // counts edges until calibrating (sel 0) or result_ready_n (sel 1) shows lvl
  task automatic wt(input bit sel, input logic lvl, output int c);
    for (c = 1; c < 6000; c++) begin
      @(negedge clock);
      if ((sel ? result_ready_n : calibrating) === lvl) return;
    end
    timeout("level wait");
  endtask
  // polling is coarse, so a settle gap follows
  task automatic wait_standby;
    int i;
    for (i = 0; i < 1000; i++) begin
      bus(1'b0, 5'h04, 32'h0, rd);
      if (rd[5:0] === 6'h04) break;
    end
    if (i == 1000) timeout("standby wait");
    repeat (100) @(posedge clock);
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t0 = $time;
    bus(1'b0, 5'h04, 32'h0, rd);
    check("start-up state", 32'h1, rd & 32'h3f);
    repeat (30) @(posedge clock);
    bus(1'b0, 5'h04, 32'h0, rd);
    check("wake status", 32'h102, rd & 32'h13f);
    bus(1'b0, 5'h14, 32'h0, rd);
    check("unmapped read", 32'h0, rd);
    wt(1'b0, 1'b1, n);
    check("wake length", 32'h1, (($time - t0) / 8) inside {[1820:1826]});
    i_host.set_pins(1'b0, 1'b1, 2'b00, 1'b0);
    wt(1'b0, 1'b0, n);
    check("cal length", 32'd3246, n);
    wt(1'b1, 1'b0, n);
    check("first conversion", 32'h1, n inside {[1623:1626]});
    check("result", 32'h12345, result_data);
    t0 = $time;
    @(posedge clock);
    filter_result <= 20'h0f00f;
    i_host.set_pins(1'b0, 1'b1, 2'b00, 1'b1);
    wt(1'b1, 1'b1, a);
    wt(1'b1, 1'b0, n);
    check("conversion period", 32'd1622, 32'(($time - t0) / 8));
    check("bipolar result", 32'h8f00f, result_data);
    bus(1'b0, 5'h0c, 32'h0, rd);
    check("offset coefficient", 32'h00abc, rd);
    bus(1'b0, 5'h10, 32'h0, rd);
    check("gain coefficient", 32'h7f0e1, rd);
    bus(1'b0, 5'h04, 32'h0, rd);
    check("conversion status", 32'h20010, rd & 32'h2003f);
    $display("test power-on calibration done");
    i_host.set_pins(1'b0, 1'b0, 2'b10, 1'b0);
    wait_standby;
    i_host.set_pins(1'b0, 1'b1, 2'b10, 1'b0);
    wt(1'b1, 1'b1, a);
    wt(1'b1, 1'b0, n);
    check("standby conversion", 32'h1, (a + n) inside {[1626:1631]});
    check("channel", 32'h2, active_channel);
    i_host.set_pins(1'b0, 1'b0, 2'b10, 1'b0);
    wait_standby;
    $display("test standby conversion done");
    i_host.set_pins(1'b1, 1'b1, 2'b01, 1'b0);
    wt(1'b0, 1'b1, n);
    check("cal entry", 32'h1, n inside {[2:6]});
    t0 = $time;
    repeat (1000) @(posedge clock);
    i_host.set_pins(1'b1, 1'b0, 2'b11, 1'b1);
    i_host.set_pins(1'b1, 1'b1, 2'b11, 1'b1);
    i_host.set_pins(1'b0, 1'b0, 2'b11, 1'b1);
    wt(1'b0, 1'b0, n);
    check("restarted cal", 32'h1, (($time - t0) / 8) inside {[4248:4258]});
    bus(1'b0, 5'h04, 32'h0, rd);
    check("standby after cal", 32'h4, rd & 32'h3f);
    $display("test cal restart done");
    i_host.set_pins(1'b1, 1'b1, 2'b01, 1'b0);
    wt(1'b0, 1'b1, n);
    t0 = $time;
    i_host.set_pins(1'b0, 1'b0, 2'b01, 1'b0);
    repeat (100) @(posedge clock);
    i_host.set_pins(1'b0, 1'b1, 2'b01, 1'b0);
    wt(1'b0, 1'b0, n);
    check("cal kept", 32'd3246, 32'(($time - t0) / 8));
    wt(1'b1, 1'b0, n);
    check("conversion after cal", 32'h1, n inside {[1623:1626]});
    check("latched channel", 32'h1, active_channel);
    i_host.set_pins(1'b0, 1'b0, 2'b01, 1'b0);
    wait_standby;
    $display("test ignored sample edge done");
    bus(1'b1, 5'h00, 32'h1, rd);
    bus(1'b0, 5'h04, 32'h0, rd);
    check("sleep state", 32'h20, rd & 32'h3f);
    i_host.set_pins(1'b1, 1'b0, 2'b00, 1'b0);
    i_host.set_pins(1'b1, 1'b1, 2'b00, 1'b0);
    bus(1'b1, 5'h00, 32'h0, rd);
    t0 = $time;
    wt(1'b0, 1'b1, n);
    check("sleep exit wake", 32'h1, (($time - t0) / 8) inside {[1800:1806]});
    i_host.set_pins(1'b0, 1'b1, 2'b00, 1'b0);
    wt(1'b0, 1'b0, n);
    check("wake cal length", 32'd3246, n);
    i_host.set_pins(1'b1, 1'b1, 2'b00, 1'b0);
    wt(1'b0, 1'b1, n);
    check("cal from conversion", 32'h1, n inside {[2:6]});
    i_host.set_pins(1'b0, 1'b1, 2'b00, 1'b0);
    $display("test sleep done");
    report_and_stop;
  end
endmodule // adc_state_sequencer_tb
